// ===== src/dcrm_pkg.sv
`default_nettype none
package dcrm_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_MAX = 7'h7E;
  localparam logic [6:0] ADDR_OFFSET = 7'h40;
  // time base: printed figures, then derived cycle and millisecond counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int FIRST_WAIT_S = 1;
  localparam int CAP_WAIT_S = 32;
  localparam int WAIT_W = 16;
  localparam logic [15:0] FIRST_WAIT_MS = 16'(FIRST_WAIT_S * MS_PER_S);
  localparam logic [15:0] CAP_WAIT_MS = 16'(CAP_WAIT_S * MS_PER_S);
  localparam logic [15:0] ONE_MS = 16'h0001;
  localparam logic [3:0] PARAM_REDUND_IDX = 4'hF;
  localparam logic [7:0] PARAM15_RESET = 8'h00;
  localparam int P15_OFFSET_BIT = 0;
  localparam int P15_SIMPLE_BIT = 1;
  localparam logic [7:0] DIAG_HEADER = 8'h08;
  localparam logic [7:0] DIAG_STATUS_TYPE = 8'h9F;
  localparam logic [7:0] DIAG_SLOT = 8'h00;
  localparam int RED_ROLE_BIT = 0;
  localparam int RED_OK_BIT = 1;
  localparam int ST_PRIMARY_BIT = 0;
  localparam int ST_BACKUP_OK_BIT = 1;
  localparam int ST_OFFSET_BIT = 2;
  localparam int ST_SIMPLE_BIT = 3;
  localparam int ST_HUNT_BIT = 4;
  typedef enum logic [2:0] {
    KIND_DATA = 3'h0,
    KIND_MOTION = 3'h1,
    KIND_CONFIG = 3'h2,
    KIND_PARAM = 3'h3,
    KIND_DIAG = 3'h4
  } dcrm_kind_t;
  typedef enum logic [1:0] {
    ST_HUNT = 2'h0,
    ST_RUN = 2'h1
  } dcrm_state_t;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    dcrm_kind_t kind;
    logic [3:0] index;
    logic [7:0] data;
  } dcrm_msg_t;
  typedef struct packed {
    logic [7:0] header;
    logic [7:0] stype;
    logic [7:0] slot;
    logic [7:0] state_pri;
    logic [7:0] state_bak;
  } dcrm_diag_t;
endpackage
`default_nettype wire

// ===== src/dcrm_ms_tick.sv
`default_nettype none
module dcrm_ms_tick #(
  parameter int CYCLES = dcrm_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : CW'(cnt_reg + 1'b1);
    end
  end
endmodule // dcrm_ms_tick
`default_nettype wire

// ===== src/dcrm_chan_filt.sv
`default_nettype none
module dcrm_chan_filt (
  input wire dcrm_pkg::dcrm_msg_t msg,
  input wire logic [6:0] my_addr,
  input wire logic addr_ok,
  input wire logic is_primary,
  output logic hit,
  output logic motion_pass,
  output logic cfg_hit,
  output logic param15_hit,
  output logic diag_hit
);
  always_comb begin
    hit = msg.valid && addr_ok && (msg.addr == my_addr);
    // backup stays in cyclic exchange, but never moves the actuator
    motion_pass = hit && is_primary && (msg.kind == dcrm_pkg::KIND_MOTION);
    cfg_hit = hit && (msg.kind == dcrm_pkg::KIND_CONFIG);
    param15_hit = hit && is_primary && (msg.kind == dcrm_pkg::KIND_PARAM)
      && (msg.index == dcrm_pkg::PARAM_REDUND_IDX);
    diag_hit = hit && (msg.kind == dcrm_pkg::KIND_DIAG);
  end
endmodule // dcrm_chan_filt
`default_nettype wire

// ===== src/dcrm_top.sv
`default_nettype none
module dcrm_top #(
  parameter int MS_CYCLES = dcrm_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [6:0] station_addr,
  input wire dcrm_pkg::dcrm_msg_t ch1_msg,
  input wire dcrm_pkg::dcrm_msg_t ch2_msg,
  input wire logic [1:0] chan_fail,
  output logic primary_ch2_reg,
  output logic hunting_reg,
  output logic [6:0] ch1_addr_reg,
  output logic [6:0] ch2_addr_reg,
  output logic addr_valid_reg,
  output logic motion_valid_reg,
  output logic [7:0] motion_cmd_reg,
  output logic cfg_apply_reg,
  output logic [7:0] cfg_data_reg,
  output logic [1:0] cfg_ack_reg,
  output logic [7:0] param15_reg,
  output logic [1:0] diag_valid_reg,
  output logic [1:0] diag_ext_reg,
  output dcrm_pkg::dcrm_diag_t diag_reg,
  output logic [7:0] status_reg
);
  dcrm_pkg::dcrm_state_t fsm_reg;
  logic [15:0] wait_ms_reg;
  logic [15:0] elapsed_ms_reg;
  logic [15:0] elapsed_next;
  logic [15:0] wait_next;
  logic cfg_known_reg;
  logic ms_tick;
  logic addr_ok;
  logic offset_mode;
  logic simple_var;
  logic any_hit;
  logic expire;
  logic [1:0] is_pri;
  logic [1:0] hit;
  logic [1:0] motion_pass;
  logic [1:0] cfg_hit;
  logic [1:0] p15_hit;
  logic [1:0] diag_hit;
  logic [6:0] bak_addr;
  logic pri_cfg;
  logic bak_cfg;
  logic bak_cfg_same;
  logic [7:0] pri_cfg_data;
  logic [7:0] bak_cfg_data;
  logic [7:0] pri_motion_data;
  logic [7:0] pri_p15_data;
  logic [7:0] red_pri;
  logic [7:0] red_bak;
  logic bak_ok;

  dcrm_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .tick(ms_tick)
  );

  dcrm_chan_filt u_filt1 (
    .msg(ch1_msg),
    .my_addr(ch1_addr_reg),
    .addr_ok(addr_valid_reg),
    .is_primary(is_pri[0]),
    .hit(hit[0]),
    .motion_pass(motion_pass[0]),
    .cfg_hit(cfg_hit[0]),
    .param15_hit(p15_hit[0]),
    .diag_hit(diag_hit[0])
  );

  dcrm_chan_filt u_filt2 (
    .msg(ch2_msg),
    .my_addr(ch2_addr_reg),
    .addr_ok(addr_valid_reg),
    .is_primary(is_pri[1]),
    .hit(hit[1]),
    .motion_pass(motion_pass[1]),
    .cfg_hit(cfg_hit[1]),
    .param15_hit(p15_hit[1]),
    .diag_hit(diag_hit[1])
  );

  always_comb begin
    is_pri = {primary_ch2_reg, ~primary_ch2_reg};
    offset_mode = param15_reg[dcrm_pkg::P15_OFFSET_BIT];
    simple_var = param15_reg[dcrm_pkg::P15_SIMPLE_BIT];
    addr_ok = (station_addr <= dcrm_pkg::ADDR_MAX);
    // offset wraps in 7 bits; masters only use set addresses below 64
    bak_addr = offset_mode ? 7'(station_addr + dcrm_pkg::ADDR_OFFSET)
      : station_addr;
    any_hit = |hit;
    elapsed_next = 16'(elapsed_ms_reg + dcrm_pkg::ONE_MS);
    expire = ms_tick && (elapsed_next >= wait_ms_reg);
    wait_next = (wait_ms_reg >= dcrm_pkg::CAP_WAIT_MS) ?
      dcrm_pkg::CAP_WAIT_MS : 16'(wait_ms_reg << 1);
    pri_cfg = primary_ch2_reg ? cfg_hit[1] : cfg_hit[0];
    bak_cfg = primary_ch2_reg ? cfg_hit[0] : cfg_hit[1];
    pri_cfg_data = primary_ch2_reg ? ch2_msg.data : ch1_msg.data;
    bak_cfg_data = primary_ch2_reg ? ch1_msg.data : ch2_msg.data;
    bak_cfg_same = cfg_known_reg && (bak_cfg_data == cfg_data_reg);
    pri_motion_data = primary_ch2_reg ? ch2_msg.data : ch1_msg.data;
    pri_p15_data = primary_ch2_reg ? ch2_msg.data : ch1_msg.data;
    bak_ok = ~(primary_ch2_reg ? chan_fail[0] : chan_fail[1]);
    red_pri = 8'h00;
    red_pri[dcrm_pkg::RED_ROLE_BIT] = 1'b1;
    red_pri[dcrm_pkg::RED_OK_BIT] = ~(primary_ch2_reg ? chan_fail[1]
      : chan_fail[0]);
    red_bak = 8'h00;
    red_bak[dcrm_pkg::RED_OK_BIT] = bak_ok;
  end

  // master hunt and failover
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fsm_reg <= dcrm_pkg::ST_HUNT;
      primary_ch2_reg <= 1'b0;
      hunting_reg <= 1'b1;
      wait_ms_reg <= dcrm_pkg::FIRST_WAIT_MS;
      elapsed_ms_reg <= '0;
    end else if (clk_en) begin
      case (fsm_reg)
        dcrm_pkg::ST_HUNT: begin
          if (any_hit) begin
            fsm_reg <= dcrm_pkg::ST_RUN;
            hunting_reg <= 1'b0;
          end else if (expire) begin
            primary_ch2_reg <= ~primary_ch2_reg;
            wait_ms_reg <= wait_next;
            elapsed_ms_reg <= '0;
          end else if (ms_tick) begin
            elapsed_ms_reg <= elapsed_next;
          end
        end
        dcrm_pkg::ST_RUN: begin
          // swap only toward a healthy channel, else keep the old one
          if ((primary_ch2_reg ? chan_fail[1] : chan_fail[0]) && bak_ok) begin
            primary_ch2_reg <= ~primary_ch2_reg;
          end
        end
        default: begin
          fsm_reg <= dcrm_pkg::ST_HUNT;
          hunting_reg <= 1'b1;
        end
      endcase
    end
  end

  // addresses follow the primary role, so failover moves the set address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch1_addr_reg <= '0;
      ch2_addr_reg <= '0;
      addr_valid_reg <= 1'b0;
    end else if (clk_en) begin
      addr_valid_reg <= addr_ok;
      ch1_addr_reg <= primary_ch2_reg ? bak_addr : station_addr;
      ch2_addr_reg <= primary_ch2_reg ? station_addr : bak_addr;
    end
  end

  // redundancy parameter, primary path only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      param15_reg <= dcrm_pkg::PARAM15_RESET;
    end else if (clk_en && (|p15_hit)) begin
      param15_reg <= pri_p15_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      motion_valid_reg <= 1'b0;
      motion_cmd_reg <= '0;
    end else if (clk_en) begin
      motion_valid_reg <= |motion_pass;
      if (|motion_pass) begin
        motion_cmd_reg <= pri_motion_data;
      end
    end
  end

  // configuration: applied from primary, filtered from backup
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_apply_reg <= 1'b0;
      cfg_data_reg <= '0;
      cfg_known_reg <= 1'b0;
      cfg_ack_reg <= '0;
    end else if (clk_en) begin
      cfg_apply_reg <= pri_cfg;
      if (pri_cfg) begin
        cfg_data_reg <= pri_cfg_data;
        cfg_known_reg <= 1'b1;
      end
      cfg_ack_reg <= '0;
      if (pri_cfg) begin
        cfg_ack_reg[primary_ch2_reg] <= 1'b1;
      end
      if (bak_cfg && (bak_cfg_same || offset_mode)) begin
        cfg_ack_reg[~primary_ch2_reg] <= 1'b1;
      end
    end
  end

  // diagnostics and status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      diag_valid_reg <= '0;
      diag_ext_reg <= '0;
      diag_reg <= '0;
      status_reg <= '0;
    end else if (clk_en) begin
      diag_valid_reg <= diag_hit;
      diag_ext_reg <= diag_hit & is_pri & {2{~simple_var}};
      diag_reg.header <= dcrm_pkg::DIAG_HEADER;
      diag_reg.stype <= dcrm_pkg::DIAG_STATUS_TYPE;
      diag_reg.slot <= dcrm_pkg::DIAG_SLOT;
      diag_reg.state_pri <= red_pri;
      diag_reg.state_bak <= red_bak;
      status_reg <= '0;
      status_reg[dcrm_pkg::ST_PRIMARY_BIT] <= primary_ch2_reg;
      status_reg[dcrm_pkg::ST_BACKUP_OK_BIT] <= bak_ok;
      status_reg[dcrm_pkg::ST_OFFSET_BIT] <= offset_mode;
      status_reg[dcrm_pkg::ST_SIMPLE_BIT] <= simple_var;
      status_reg[dcrm_pkg::ST_HUNT_BIT] <= hunting_reg;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_reset_primary: assert property (
    $past(srst) |-> !primary_ch2_reg && wait_ms_reg == 16'h03E8)
    else $error("primary not channel 1 after reset");
  a_hunt_switch: assert property (
    clk_en && fsm_reg == dcrm_pkg::ST_HUNT && !any_hit && expire
    |=> primary_ch2_reg != $past(primary_ch2_reg))
    else $error("primary did not switch on expiry");
  a_wait_double: assert property (
    clk_en && fsm_reg == dcrm_pkg::ST_HUNT && !any_hit && expire
    |=> wait_ms_reg == (($past(wait_ms_reg) >= 16'h7D00) ?
      16'h7D00 : 16'($past(wait_ms_reg) << 1)))
    else $error("wait limit did not double");
  a_wait_cap: assert property (
    wait_ms_reg <= 16'h7D00 && wait_ms_reg >= 16'h03E8)
    else $error("wait limit out of range");
  a_hunt_stop: assert property (
    clk_en && fsm_reg == dcrm_pkg::ST_HUNT && any_hit
    |=> !hunting_reg ##1 fsm_reg == dcrm_pkg::ST_RUN)
    else $error("hunt did not stop on master traffic");
  a_addr_offset: assert property (
    clk_en && offset_mode && addr_ok && $stable(station_addr)
    && $stable(param15_reg) && !primary_ch2_reg
    |=> ch2_addr_reg == 7'(ch1_addr_reg + 7'h40))
    else $error("backup address not offset by 64");
  a_addr_shared: assert property (
    clk_en && !offset_mode && $stable(param15_reg)
    |=> ch1_addr_reg == ch2_addr_reg)
    else $error("shared mode addresses differ");
  a_failover: assert property (
    clk_en && fsm_reg == dcrm_pkg::ST_RUN && chan_fail[primary_ch2_reg]
    && !chan_fail[~primary_ch2_reg] |=> ##1 ch1_addr_reg ==
    ($past(primary_ch2_reg) ? $past(bak_addr) : $past(station_addr)))
    else $error("failover did not move address");
  a_motion_block: assert property (
    clk_en && !(|motion_pass) |=> !motion_valid_reg)
    else $error("backup motion command passed");
  a_backup_cfg: assert property (
    clk_en && bak_cfg && !pri_cfg && !offset_mode && !bak_cfg_same
    |=> cfg_ack_reg == 2'b00 && !cfg_apply_reg && $stable(cfg_data_reg))
    else $error("differing backup config not ignored");
  a_backup_ack: assert property (
    clk_en && bak_cfg && !pri_cfg && offset_mode
    |=> cfg_ack_reg[~primary_ch2_reg] && !cfg_apply_reg)
    else $error("backup config not acknowledged");
  a_diag_ext: assert property (
    diag_ext_reg != 2'b00 |-> !$past(simple_var)
    && diag_reg.stype == 8'h9F && diag_reg.header == 8'h08)
    else $error("extended diagnostic in simple variant");
  a_addr_range: assert property (
    clk_en && station_addr == 7'h7F |=> !addr_valid_reg)
    else $error("address 127 accepted");

  // backup traffic alone must leave every primary-only output quiet
  a_backup_motion: assert property (
    clk_en && hit[~primary_ch2_reg] && !hit[primary_ch2_reg]
    |=> !motion_valid_reg)
    else $error("motion accepted from backup alone");
  a_param_primary: assert property (
    clk_en && !hit[primary_ch2_reg] |=> $stable(param15_reg))
    else $error("parameter 15 changed without primary traffic");
  a_cfg_primary: assert property (
    clk_en && !pri_cfg |=> !cfg_apply_reg && $stable(cfg_data_reg))
    else $error("config applied without primary config");
  a_diag_primary: assert property (
    clk_en && !diag_hit[primary_ch2_reg] |=> diag_ext_reg == 2'b00)
    else $error("extended diagnostic outside the primary");
  a_status_role: assert property (
    clk_en |=> status_reg[dcrm_pkg::ST_PRIMARY_BIT] ==
    $past(primary_ch2_reg) && status_reg[dcrm_pkg::ST_BACKUP_OK_BIT] ==
    $past(bak_ok))
    else $error("status does not show roles");
  a_run_hold: assert property (
    clk_en && fsm_reg == dcrm_pkg::ST_RUN && chan_fail == 2'b00
    |=> $stable(primary_ch2_reg) && !hunting_reg)
    else $error("primary swapped after a master was found");
  a_reset_hunt: assert property (
    $past(srst) |-> hunting_reg && fsm_reg == dcrm_pkg::ST_HUNT
    && elapsed_ms_reg == 16'h0000)
    else $error("hunt not restarted by reset");

  c_hunt_swap: cover property (fsm_reg == dcrm_pkg::ST_HUNT && expire);
  c_lock: cover property (hunting_reg ##1 !hunting_reg);
  c_failover: cover property (fsm_reg == dcrm_pkg::ST_RUN
    && $changed(primary_ch2_reg));
  c_diag_ext: cover property (diag_ext_reg != 2'b00);
  c_offset_ack: cover property (cfg_ack_reg != 2'b00 && offset_mode);
endmodule // dcrm_top
`default_nettype wire

// ===== tb/dcrm_master_model.sv
`default_nettype none
module dcrm_master_model (
  input wire logic ref_clk,
  output dcrm_pkg::dcrm_msg_t msg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial msg = '0;
  // idle bus shows inverted fields so a stale address can never match
  task automatic send(input logic [6:0] addr,
                      input dcrm_pkg::dcrm_kind_t kind,
                      input logic [3:0] index, input logic [7:0] data);
    @(negedge ref_clk);
    msg <= {1'b1, addr, kind, index, data};
    @(negedge ref_clk);
    msg <= {1'b0, ~addr, ~kind, ~index, ~data};
  endtask
endmodule // dcrm_master_model
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); \
  end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SA = 7'h15;
  localparam logic [6:0] SB = 7'h55;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [6:0] station_addr = SA;
  logic [1:0] chan_fail = 2'h0;
  dcrm_pkg::dcrm_msg_t ch1_msg, ch2_msg;
  logic primary_ch2_reg, hunting_reg, addr_valid_reg, motion_valid_reg;
  logic cfg_apply_reg;
  logic [6:0] ch1_addr_reg, ch2_addr_reg;
  logic [7:0] motion_cmd_reg, cfg_data_reg, param15_reg, status_reg;
  logic [1:0] cfg_ack_reg, diag_valid_reg, diag_ext_reg;
  dcrm_pkg::dcrm_diag_t diag_reg;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int rel = 0;
  always #50 ref_clk = ~ref_clk;
  // one millisecond per cycle keeps the 95 s hunt up to the 32 s cap near 95k cycles
  dcrm_top #(.MS_CYCLES(1)) dcrm_top_i (.ref_clk(ref_clk), .srst(srst),
    .clk_en(clk_en), .station_addr(station_addr), .ch1_msg(ch1_msg),
    .ch2_msg(ch2_msg), .chan_fail(chan_fail),
    .primary_ch2_reg(primary_ch2_reg), .hunting_reg(hunting_reg),
    .ch1_addr_reg(ch1_addr_reg), .ch2_addr_reg(ch2_addr_reg),
    .addr_valid_reg(addr_valid_reg), .motion_valid_reg(motion_valid_reg),
    .motion_cmd_reg(motion_cmd_reg), .cfg_apply_reg(cfg_apply_reg),
    .cfg_data_reg(cfg_data_reg), .cfg_ack_reg(cfg_ack_reg),
    .param15_reg(param15_reg), .diag_valid_reg(diag_valid_reg),
    .diag_ext_reg(diag_ext_reg), .diag_reg(diag_reg),
    .status_reg(status_reg));
  dcrm_master_model master1_i (.ref_clk(ref_clk), .msg(ch1_msg));
  dcrm_master_model master2_i (.ref_clk(ref_clk), .msg(ch2_msg));
  task automatic final_report();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic do_reset();
    srst = 1'b1;
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    rel = cyc;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic t_reset_vals();
    `CHK(primary_ch2_reg, 1'b0)
    `CHK(hunting_reg, 1'b1)
    `CHK(status_reg[4], 1'b1)
    `CHK(param15_reg, 8'h00)
    `CHK(addr_valid_reg, 1'b1)
    `CHK(ch1_addr_reg, SA)
    `CHK(ch2_addr_reg, SA)
  endtask
  task automatic t_motion();
    master1_i.send(SA, dcrm_pkg::KIND_MOTION, 4'h0, 8'hA5);
    `CHK(motion_valid_reg, 1'b1)
    `CHK(motion_cmd_reg, 8'hA5)
    @(negedge ref_clk);
    `CHK(hunting_reg, 1'b0)
    master2_i.send(SA, dcrm_pkg::KIND_MOTION, 4'h0, 8'h3C);
    `CHK(motion_valid_reg, 1'b0)
    `CHK(motion_cmd_reg, 8'hA5)
    // a frozen block must not take a primary command either
    clk_en = 1'b0;
    master1_i.send(SA, dcrm_pkg::KIND_MOTION, 4'h0, 8'h96);
    `CHK(motion_valid_reg, 1'b0)
    `CHK(motion_cmd_reg, 8'hA5)
    clk_en = 1'b1;
  endtask
  task automatic t_cfg_shared();
    master1_i.send(SA, dcrm_pkg::KIND_CONFIG, 4'h0, 8'h11);
    `CHK(cfg_apply_reg, 1'b1)
    `CHK(cfg_data_reg, 8'h11)
    master2_i.send(SA, dcrm_pkg::KIND_CONFIG, 4'h0, 8'h22);
    `CHK(cfg_ack_reg, 2'h0)
    `CHK(cfg_apply_reg, 1'b0)
    master2_i.send(SA, dcrm_pkg::KIND_CONFIG, 4'h0, 8'h11);
    `CHK(cfg_ack_reg, 2'h2)
    `CHK(cfg_data_reg, 8'h11)
    master2_i.send(SA, dcrm_pkg::KIND_PARAM, 4'hF, 8'h01);
    `CHK(param15_reg, 8'h00)
  endtask
  task automatic t_offset();
    master1_i.send(SA, dcrm_pkg::KIND_PARAM, 4'hF, 8'h01);
    `CHK(param15_reg, 8'h01)
    @(negedge ref_clk);
    `CHK(ch1_addr_reg, SA)
    `CHK(ch2_addr_reg, SB)
    `CHK(status_reg[2], 1'b1)
    master2_i.send(SB, dcrm_pkg::KIND_CONFIG, 4'h0, 8'h33);
    `CHK(cfg_ack_reg, 2'h2)
    `CHK(cfg_apply_reg, 1'b0)
    `CHK(cfg_data_reg, 8'h11)
    master2_i.send(SB, dcrm_pkg::KIND_MOTION, 4'h0, 8'h77);
    `CHK(motion_valid_reg, 1'b0)
  endtask
  task automatic t_diag();
    master1_i.send(SA, dcrm_pkg::KIND_DIAG, 4'h0, 8'h00);
    `CHK(diag_valid_reg, 2'h1)
    `CHK(diag_ext_reg, 2'h1)
    `CHK(diag_reg.header, 8'h08)
    `CHK(diag_reg.stype, 8'h9F)
    `CHK(diag_reg.slot, 8'h00)
    `CHK(diag_reg.state_pri[1:0], 2'h3)
    `CHK(diag_reg.state_bak[1:0], 2'h2)
    `CHK(status_reg[1], 1'b1)
    master2_i.send(SB, dcrm_pkg::KIND_DIAG, 4'h0, 8'h00);
    `CHK(diag_valid_reg, 2'h2)
    `CHK(diag_ext_reg, 2'h0)
    master1_i.send(SA, dcrm_pkg::KIND_PARAM, 4'hF, 8'h03);
    master1_i.send(SA, dcrm_pkg::KIND_DIAG, 4'h0, 8'h00);
    `CHK(diag_valid_reg, 2'h1)
    `CHK(diag_ext_reg, 2'h0)
    `CHK(status_reg[3], 1'b1)
  endtask
  task automatic t_failover();
    chan_fail = 2'h1;
    repeat (2) @(negedge ref_clk);
    `CHK(primary_ch2_reg, 1'b1)
    `CHK(ch2_addr_reg, SA)
    `CHK(ch1_addr_reg, SB)
    `CHK(status_reg[1:0], 2'h1)
    master2_i.send(SA, dcrm_pkg::KIND_MOTION, 4'h0, 8'h5A);
    `CHK(motion_cmd_reg, 8'h5A)
    master2_i.send(SA, dcrm_pkg::KIND_PARAM, 4'hF, 8'h00);
    chan_fail = 2'h2;
    repeat (2) @(negedge ref_clk);
    `CHK(primary_ch2_reg, 1'b0)
    `CHK(ch1_addr_reg, SA)
    `CHK(ch2_addr_reg, SA)
    master1_i.send(SA, dcrm_pkg::KIND_MOTION, 4'h0, 8'hC3);
    `CHK(motion_valid_reg, 1'b1)
    chan_fail = 2'h0;
  endtask
  task automatic t_range();
    station_addr = 7'h7F;
    repeat (2) @(negedge ref_clk);
    `CHK(addr_valid_reg, 1'b0)
    master1_i.send(7'h7F, dcrm_pkg::KIND_MOTION, 4'h0, 8'h01);
    `CHK(motion_valid_reg, 1'b0)
    station_addr = 7'h7E;
    repeat (2) @(negedge ref_clk);
    `CHK(addr_valid_reg, 1'b1)
    master1_i.send(7'h7E, dcrm_pkg::KIND_MOTION, 4'h0, 8'h02);
    `CHK(motion_valid_reg, 1'b1)
    station_addr = SA;
  endtask
  // margins absorb the one cycle of tick start-up after reset
  task automatic t_hunt();
    int t[7] = '{1000, 3000, 7000, 15000, 31000, 63000, 95000};
    do_reset();
    `CHK(primary_ch2_reg, 1'b0)
    for (int k = 0; k < 7; k++) begin
      while (cyc - rel < t[k] - 20) @(negedge ref_clk);
      `CHK(primary_ch2_reg, k[0])
      `CHK(hunting_reg, 1'b1)
      while (cyc - rel < t[k] + 20) @(negedge ref_clk);
      `CHK(primary_ch2_reg, ~k[0])
    end
    master2_i.send(SA, dcrm_pkg::KIND_DATA, 4'h0, 8'h00);
    repeat (2000) @(negedge ref_clk);
    `CHK(hunting_reg, 1'b0)
    `CHK(primary_ch2_reg, 1'b1)
  endtask
  initial begin
    do_reset();
    t_reset_vals();
    t_motion();
    t_cfg_shared();
    t_offset();
    t_diag();
    t_failover();
    t_range();
    t_hunt();
    final_report();
  end
endmodule // tb
`undef CHK
`default_nettype wire
